//--- hw/pmt_pkg.sv
/*
 * pmt_pkg: constants and types shared by the period match timer files.
 * Assumes an APB slave with 32-bit data and 12-bit byte addresses; each
 * register index is placed at byte address index * 4.
 */
package pmt_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices as printed
    localparam logic [7:0] IDX_IRQ_GLOBAL = 8'h0b;
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_COUNT_VALUE = 8'h11;
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'h12;
    localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h93;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h94;

    // byte addresses, index times four
    localparam logic [11:0] ADDR_IRQ_GLOBAL = {2'h0, IDX_IRQ_GLOBAL, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_FLAGS = {2'h0, IDX_PERIPH_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_COUNT_VALUE = {2'h0, IDX_COUNT_VALUE, 2'h0};
    localparam logic [11:0] ADDR_TIMER_CONTROL = {2'h0, IDX_TIMER_CONTROL, 2'h0};
    localparam logic [11:0] ADDR_PERIPH_ENABLES = {2'h0, IDX_PERIPH_ENABLES, 2'h0};
    localparam logic [11:0] ADDR_PERIOD_LIMIT = {2'h0, IDX_PERIOD_LIMIT, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

    // field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPH_IRQ_GATE_BIT = 6;
    localparam int MATCH_FLAG_BIT = 1;
    localparam int MATCH_IRQ_ENABLE_BIT = 1;
    localparam int STAT_W = 2;
    localparam int STAT_POSTSCALED = 0;
    localparam int STAT_RAW_MATCH = 1;

    // values after reset
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h3;

    // cycle counts: pclk is the oscillator, the instruction clock is a quarter
    localparam int INSTR_DIV = 4;
    localparam int PRE_DIV_1 = 1;
    localparam int PRE_DIV_4 = 4;
    localparam int PRE_DIV_16 = 16;
    localparam int PRE_CNT_W = 6;
    localparam int POST_CNT_W = 4;

    // timer control layout, bit 7 unimplemented
    typedef struct packed {
        logic unused;
        logic [3:0] postscale_select;
        logic run_enable;
        logic [1:0] prescale_select;
    } pmt_ctrl_s;

    localparam pmt_ctrl_s CTRL_RESET = '{default: 1'b0};

endpackage

//--- hw/pmt_prescale.sv
/*
 * pmt_prescale: divides pclk down to the instruction clock and then by
 * 1, 4 or 16, giving one tick pulse per timer increment.
 * Assumes the parent gates run and pulses clr on control or count writes.
 */
module pmt_prescale
    import pmt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clr,
    input wire logic run,
    input wire logic [1:0] sel,
    // output
    output logic tick
);
    logic [PRE_CNT_W-1:0] cnt_q, cnt_d, limit;

    // terminal count, 16x (sel 2 or 3) selects the largest division
    always_comb begin
        unique case (sel)
            2'h0: limit = PRE_CNT_W'(INSTR_DIV * PRE_DIV_1 - 1);
            2'h1: limit = PRE_CNT_W'(INSTR_DIV * PRE_DIV_4 - 1);
            default: limit = PRE_CNT_W'(INSTR_DIV * PRE_DIV_16 - 1);
        endcase
        tick = run & ~clr & (cnt_q >= limit);
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = '0;
        end else if (run) begin
            cnt_d = cnt_q + PRE_CNT_W'(1);
        end
    end

    // held while stopped, so no partial count leaks out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- hw/pmt_postscale.sv
/*
 * pmt_postscale: passes one of every (sel + 1) match pulses.
 * Assumes match pulses last one cycle; clr wins over a pulse.
 */
module pmt_postscale
    import pmt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic clr,
    input wire logic [3:0] sel,
    input wire logic pulse,
    // output
    output logic out
);
    logic [POST_CNT_W-1:0] cnt_q, cnt_d;

    // count pulses, emit on the last one of the group
    always_comb begin
        out = pulse & ~clr & (cnt_q == sel);
        cnt_d = cnt_q;
        if (clr || out) begin
            cnt_d = '0;
        end else if (pulse) begin
            cnt_d = cnt_q + POST_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

//--- hw/pmt_timer.sv
/*
 * pmt_timer: 8-bit period match timer with prescaler, postscaler,
 * serial port shift tick, flag and interrupt registers, APB slave.
 * Assumes an APB master on pclk; the serial port samples ssp_shift_tick.
 */
// Contract
// - The counter counts up from zero and wraps to zero on the increment after it equals the period.
// - An 8-bit period register, apart from the counter, is readable and writable at any time.
// - Reset loads the period register with all ones.
// - The match pulse, before the postscaler, goes out to the serial port as a shift tick.
// - The counter is clocked by the instruction clock through a 1, 4 or 16 prescaler.
// - Match pulses pass a 1 to 16 postscaler whose output sets the match flag, bit 1 of the flags.
// - Count or control writes and reset clear both scalers; a control write keeps the count.
// - The counter advances only while the run enable bit 2 of the control register is set.
module pmt_timer
    import pmt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmt_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmt_pkg::DATA_W-1:0] pwdata,
    output logic [pmt_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // to serial port and cpu
    output logic ssp_shift_tick,
    output logic irq
);
    pmt_ctrl_s ctrl_q, ctrl_d;
    logic [7:0] count_q, count_d, period_q, period_d;
    logic gie_q, gie_d, peripheral_irq_gate_q, peripheral_irq_gate_d, flag_q, flag_d, ie_q, ie_d;
    logic [STAT_W-1:0] status_q, status_d, mask_q, mask_d, stat_ev;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d, ssp_q, ssp_d;
    logic access, done, wr, rd_status, mapped;
    logic [7:0] rdata;
    logic wr_count, wr_ctrl, scale_clr, tick, match, post_tick;

    // apb phases: pready rises one cycle into the access phase
    assign access = psel & penable;
    assign done = access & pready_q;
    assign wr = done & pwrite;
    assign wr_count = wr & (paddr == ADDR_COUNT_VALUE);
    assign wr_ctrl = wr & (paddr == ADDR_TIMER_CONTROL);
    assign rd_status = done & ~pwrite & (paddr == ADDR_IRQ_STATUS);
    assign scale_clr = wr_count | wr_ctrl;

    // scalers
    pmt_prescale u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scale_clr),
        .run(ctrl_q.run_enable),
        .sel(ctrl_q.prescale_select),
        .tick(tick)
    );

    assign match = tick & (count_q == period_q);

    pmt_postscale u_post (
        .pclk(pclk),
        .presetn(presetn),
        .clr(scale_clr),
        .sel(ctrl_q.postscale_select),
        .pulse(match),
        .out(post_tick)
    );

    // counter: a bus write wins over an increment in the same cycle
    // the write wins so software reads back exactly the value it stored
    always_comb begin
        count_d = count_q;
        if (wr_count) begin
            count_d = pwdata[7:0];
        end else if (tick) begin
            count_d = match ? COUNT_RESET : count_q + 8'h01;
        end
    end

    // read mux, unimplemented bits read zero
    always_comb begin
        mapped = 1'b1;
        rdata = 8'h00;
        unique case (paddr)
            ADDR_IRQ_GLOBAL: begin
                rdata[GLOBAL_IRQ_ENABLE_BIT] = gie_q;
                rdata[PERIPH_IRQ_GATE_BIT] = peripheral_irq_gate_q;
            end
            ADDR_PERIPH_FLAGS: rdata[MATCH_FLAG_BIT] = flag_q;
            ADDR_COUNT_VALUE: rdata = count_q;
            ADDR_TIMER_CONTROL: rdata = {1'b0, ctrl_q[6:0]};
            ADDR_PERIPH_ENABLES: rdata[MATCH_IRQ_ENABLE_BIT] = ie_q;
            ADDR_PERIOD_LIMIT: rdata = period_q;
            ADDR_IRQ_STATUS: rdata = {6'h00, status_q};
            ADDR_IRQ_MASK: rdata = {6'h00, mask_q};
            default: mapped = 1'b0;
        endcase
    end

    // bus answer: data and error captured with pready
    // one fixed wait state gives the read mux a full cycle before the answer
    always_comb begin
        pready_d = access & ~pready_q;
        pslverr_d = access & ~pready_q & ~mapped;
        prdata_d = prdata_q;
        if (access && !pready_q) begin
            prdata_d = {24'h000000, rdata};
        end
    end

    // software registers; hardware set wins over a software clear
    always_comb begin
        ctrl_d = ctrl_q;
        period_d = period_q;
        gie_d = gie_q;
        peripheral_irq_gate_d = peripheral_irq_gate_q;
        ie_d = ie_q;
        flag_d = flag_q;
        mask_d = mask_q;
        if (wr) begin
            unique case (paddr)
                ADDR_IRQ_GLOBAL: begin
                    gie_d = pwdata[GLOBAL_IRQ_ENABLE_BIT];
                    peripheral_irq_gate_d = pwdata[PERIPH_IRQ_GATE_BIT];
                end
                ADDR_PERIPH_FLAGS: flag_d = pwdata[MATCH_FLAG_BIT];
                ADDR_TIMER_CONTROL: ctrl_d = pmt_ctrl_s'({1'b0, pwdata[6:0]});
                ADDR_PERIPH_ENABLES: ie_d = pwdata[MATCH_IRQ_ENABLE_BIT];
                ADDR_PERIOD_LIMIT: period_d = pwdata[7:0];
                ADDR_IRQ_MASK: mask_d = pwdata[STAT_W-1:0];
                default: ;
            endcase
        end
        if (post_tick) begin
            flag_d = 1'b1;
        end
        ssp_d = match;
        irq_d = gie_q & peripheral_irq_gate_q & flag_q & ie_q & (|(status_q & mask_q));
    end

    // sticky status; a read clears only bits it returned, so late events stay
    assign stat_ev[STAT_POSTSCALED] = post_tick;
    assign stat_ev[STAT_RAW_MATCH] = match;
    for (genvar i = 0; i < STAT_W; i++) begin : g_stat
        assign status_d[i] = stat_ev[i] | (status_q[i] & ~(rd_status & prdata_q[i]));
    end

    // all state registers except the gap helper
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            count_q <= COUNT_RESET;
            period_q <= PERIOD_RESET;
            gie_q <= 1'b0;
            peripheral_irq_gate_q <= 1'b0;
            ie_q <= 1'b0;
            flag_q <= 1'b0;
            status_q <= STATUS_RESET;
            mask_q <= MASK_RESET;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            ssp_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            period_q <= period_d;
            gie_q <= gie_d;
            peripheral_irq_gate_q <= peripheral_irq_gate_d;
            ie_q <= ie_d;
            flag_q <= flag_d;
            status_q <= status_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            ssp_q <= ssp_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ssp_shift_tick = ssp_q;
    assign irq = irq_q;

    // helper: cycles spent running since the last tick or clear
    logic [PRE_CNT_W:0] gap_q;
    logic seen_q;
    logic [PRE_CNT_W:0] gap_want;
    always_comb begin
        unique case (ctrl_q.prescale_select)
            2'h0: gap_want = (PRE_CNT_W+1)'(INSTR_DIV * PRE_DIV_1 - 1);
            2'h1: gap_want = (PRE_CNT_W+1)'(INSTR_DIV * PRE_DIV_4 - 1);
            default: gap_want = (PRE_CNT_W+1)'(INSTR_DIV * PRE_DIV_16 - 1);
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else if (scale_clr || tick) begin
            gap_q <= '0;
            seen_q <= 1'b1;
        end else if (ctrl_q.run_enable) begin
            gap_q <= gap_q + (PRE_CNT_W+1)'(1);
        end
    end

    wrap_to_zero_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        match && !wr_count |=> count_q == 8'h00)
    else $error("count did not wrap to zero after match");

    count_step_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        tick && !match && !wr_count |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step by one");

    period_write_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ADDR_PERIOD_LIMIT |=> period_q == $past(pwdata[7:0]))
    else $error("period write not stored");

    period_reset_a:
    assert property (@(posedge pclk) !presetn |=> period_q == 8'hff)
    else $error("period not all ones in reset");

    shift_tick_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        match |=> ssp_shift_tick ##1 !ssp_shift_tick || $past(match))
    else $error("shift tick does not follow match");

    prescale_gap_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        tick && seen_q && !$past(scale_clr) |-> gap_q == gap_want)
    else $error("prescaler spacing wrong");

    post_flag_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        post_tick |=> flag_q && status_q[STAT_POSTSCALED])
    else $error("postscaler output did not set flag");

    ctrl_keeps_count_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> count_q == $past(count_q) && !tick)
    else $error("control write disturbed count or scaler");

    hold_stopped_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.run_enable && !wr_count |=> $stable(count_q))
    else $error("count moved while stopped");

    irq_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(gie_q) && $past(peripheral_irq_gate_q) && $past(flag_q) && $past(ie_q))
    else $error("interrupt without full gate");

    // bus answer, count write, shift tick, flag and status checks beyond the timer rules
    ready_one_cycle_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
    else $error("pready stood longer than one cycle");

    error_with_ready_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
    else $error("error answer without ready");

    upper_read_zero_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[DATA_W-1:8] == 24'h000000)
    else $error("unused read bits not zero");

    count_write_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        wr_count |=> count_q == $past(pwdata[7:0]) && !tick)
    else $error("count write not stored or scaler not cleared");

    match_on_period_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        ssp_shift_tick |-> $past(count_q) == $past(period_q))
    else $error("shift tick without period match");

    flag_set_wins_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        post_tick && wr && paddr == ADDR_PERIPH_FLAGS |=> flag_q)
    else $error("flag clear beat a postscaler event");

    irq_needs_status_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(|(status_q & mask_q)))
    else $error("interrupt without unmasked status");

    status_sticky_a:
    assert property (@(posedge pclk) disable iff (!presetn)
        status_q[STAT_RAW_MATCH] && !rd_status |=> status_q[STAT_RAW_MATCH])
    else $error("status bit lost without a read");
endmodule

//--- tb/pmt_ssp_model.sv
/*
 * pmt_ssp_model: serial port shift logic that takes the timer match tick
 * as its shift clock and records the spacing between ticks.
 * Assumes the tick is a one-cycle pulse on pclk.
 */
module pmt_ssp_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // shift clock source
    input wire logic shift_tick,
    // observed timing
    output int gap,
    output int seen
);
    timeunit 1ns;
    timeprecision 1ps;
    int since;
    // shift logic only sees the raw tick, so it counts clocks between pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since <= 0;
            gap <= 0;
            seen <= 0;
        end else if (shift_tick) begin
            gap <= since + 1;
            since <= 0;
            seen <= seen + 1;
        end else begin
            since <= since + 1;
        end
    end
endmodule

//--- tb/pmt_timer_tb_top.sv
/*
 * pmt_timer_tb_top: self-checking bench for the period match timer.
 * Assumes a 100 MHz pclk and the register map of pmt_pkg.
 */
module pmt_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmt_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic ssp_shift_tick;
    logic irq;
    int gap;
    int seen;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    pmt_timer i_pmt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ssp_shift_tick(ssp_shift_tick), .irq(irq));
    pmt_ssp_model i_pmt_ssp_model (.pclk(pclk), .presetn(presetn), .shift_tick(ssp_shift_tick),
        .gap(gap), .seen(seen));
    always #5 pclk = ~pclk;
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // a hang is cut here; the ceiling leaves ample room over the planned run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    // one apb transfer; an idle edge follows so the next setup never collides
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk_val(r, exp);
        chk_bit(e, exp_err);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // values after reset, period read and write, unmapped refusal
    task automatic t_reset();
        rd_chk(ADDR_PERIOD_LIMIT, 32'h000000ff, 1'b0);
        rd_chk(ADDR_COUNT_VALUE, 32'h00000000, 1'b0);
        rd_chk(ADDR_TIMER_CONTROL, 32'h00000000, 1'b0);
        rd_chk(ADDR_IRQ_MASK, 32'h00000003, 1'b0);
        rd_chk(12'h004, 32'h00000000, 1'b1);
        wr(12'h004, 32'h000000aa);
        wr(ADDR_PERIOD_LIMIT, 32'h0000005a);
        rd_chk(ADDR_PERIOD_LIMIT, 32'h0000005a, 1'b0);
        $display("test reset done");
    endtask
    // tick spacing is four clocks times prescale times period plus one
    task automatic t_gap(input logic [7:0] ctrl, input logic [7:0] per, input int exp);
        int s0;
        int n = 0;
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wr(ADDR_COUNT_VALUE, 32'h0);
        wr(ADDR_PERIOD_LIMIT, {24'h0, per});
        wr(ADDR_TIMER_CONTROL, {24'h0, ctrl});
        s0 = seen;
        while (seen < s0 + 2 && n < 3 * exp + 50) begin
            @(posedge pclk);
            n++;
        end
        chk_bit(seen >= s0 + 2, 1'b1);
        chk_val(gap, exp);
        $display("test gap %h done", ctrl);
    endtask
    // stopped count holds; a control write keeps it and restarts the prescaler
    task automatic t_hold();
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wr(ADDR_COUNT_VALUE, 32'h37);
        wr(ADDR_TIMER_CONTROL, 32'h0);
        wait_cyc(100);
        rd_chk(ADDR_COUNT_VALUE, 32'h37, 1'b0);
        wr(ADDR_PERIOD_LIMIT, 32'hff);
        wr(ADDR_COUNT_VALUE, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_TIMER_CONTROL, 32'h06);
            wait_cyc(30);
        end
        wr(ADDR_TIMER_CONTROL, 32'h0);
        rd_chk(ADDR_COUNT_VALUE, 32'h0, 1'b0);
        $display("test hold done");
    endtask
    task automatic wait_irq(input logic lvl);
        int n = 0;
        while (irq !== lvl && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk_bit(irq, lvl);
    endtask
    // postscale by three, gate chain and mask
    task automatic t_irq();
        int s1;
        wr(ADDR_COUNT_VALUE, 32'h0);
        wr(ADDR_PERIOD_LIMIT, 32'h01);
        wr(ADDR_IRQ_GLOBAL, 32'hc0);
        wr(ADDR_PERIPH_ENABLES, 32'h02);
        wr(ADDR_TIMER_CONTROL, 32'h14);
        wait_irq(1'b1);
        s1 = seen;
        wr(ADDR_PERIPH_FLAGS, 32'h0);
        rd_chk(ADDR_PERIPH_FLAGS, 32'h0, 1'b0);
        wait_irq(1'b1);
        chk_val(seen - s1, 3);
        rd_chk(ADDR_PERIPH_FLAGS, 32'h02, 1'b0);
        wr(ADDR_IRQ_GLOBAL, 32'h80);
        wait_cyc(12);
        chk_bit(irq, 1'b0);
        wr(ADDR_IRQ_GLOBAL, 32'h40);
        wait_cyc(12);
        chk_bit(irq, 1'b0);
        wr(ADDR_IRQ_GLOBAL, 32'hc0);
        wait_cyc(12);
        chk_bit(irq, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0);
        wait_cyc(12);
        chk_bit(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h3);
        wait_cyc(12);
        chk_bit(irq, 1'b1);
        wr(ADDR_PERIPH_ENABLES, 32'h0);
        wait_cyc(12);
        chk_bit(irq, 1'b0);
        wr(ADDR_TIMER_CONTROL, 32'h0);
        rd_chk(ADDR_IRQ_STATUS, 32'h00000003, 1'b0);
        rd_chk(ADDR_IRQ_STATUS, 32'h00000000, 1'b0);
        $display("test irq done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_gap(8'h04, 8'h02, 12);
        t_gap(8'h05, 8'h02, 48);
        t_gap(8'h06, 8'h02, 192);
        t_gap(8'h07, 8'h02, 192);
        t_hold();
        t_irq();
        final_report();
    end
endmodule
